// ===== telemetry_pkg.sv
/*
 Constants, types and group table of the telemetry broadcast scheduler.
 Assumes a 100 MHz clock and a word-indexed register port.
*/
package telemetry_pkg;
   localparam logic [7:0] IDX_RAW_RATES = 8'h01;
   localparam logic [7:0] IDX_TEMP_RATES = 8'h02;
   localparam logic [7:0] IDX_FILT_RATES = 8'h03;
   localparam logic [7:0] IDX_EVERY_FILT = 8'h04;
   localparam logic [7:0] IDX_STATUS = 8'h10;

   localparam int FLD_B3_LSB = 24;
   localparam int FLD_B2_LSB = 16;
   localparam int FLD_B1_LSB = 8;
   localparam int FLD_B0_LSB = 0;
   localparam logic [7:0] RATE_RST = 8'h00;

   localparam int CLK_PERIOD_NS = 10;
   localparam int BASE_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES_DEF = BASE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PRESC_W = 20;
   localparam int ACC_W = 10;
   localparam logic [ACC_W-1:0] BASE_HZ_DEF = 10'h3e8;

   localparam int NUM_GROUPS = 9;
   localparam logic [3:0] GRP_RAW_ANGULAR = 4'h0;
   localparam logic [3:0] GRP_RAW_ACCEL = 4'h1;
   localparam logic [3:0] GRP_RAW_COMPASS = 4'h2;
   localparam logic [3:0] GRP_TEMP = 4'h3;
   localparam logic [3:0] GRP_ALL_RAW = 4'h4;
   localparam logic [3:0] GRP_FILT_ANGULAR = 4'h5;
   localparam logic [3:0] GRP_FILT_ACCEL = 4'h6;
   localparam logic [3:0] GRP_FILT_COMPASS = 4'h7;
   localparam logic [3:0] GRP_ALL_FILT = 4'h8;

   localparam logic [7:0] ADDR_RAW_ANGULAR = 8'h56;
   localparam logic [7:0] ADDR_RAW_ACCEL = 8'h59;
   localparam logic [7:0] ADDR_RAW_COMPASS = 8'h5c;
   localparam logic [7:0] ADDR_TEMP = 8'h5f;
   localparam logic [7:0] ADDR_ALL_RAW = 8'h56;
   localparam logic [7:0] ADDR_FILT_ANGULAR = 8'h64;
   localparam logic [7:0] ADDR_FILT_ACCEL = 8'h68;
   localparam logic [7:0] ADDR_FILT_COMPASS = 8'h6c;
   localparam logic [7:0] ADDR_ALL_FILT = 8'h61;
   localparam logic [3:0] LEN_RAW_SINGLE = 4'h3;
   localparam logic [3:0] LEN_TEMP = 4'h2;
   localparam logic [3:0] LEN_ALL_RAW = 4'hb;
   localparam logic [3:0] LEN_FILT_SINGLE = 4'h4;
   localparam logic [3:0] LEN_ALL_FILT = 4'hc;

   typedef enum logic [1:0] {
      SCHED_IDLE = 2'b01,
      SCHED_OFFER = 2'b10
   } sched_fsm_type;

   typedef struct packed {
      logic [7:0] start_addr;
      logic [3:0] length;
   } batch_type;

   typedef struct packed {
      logic [7:0] raw_accelerometer_hz;
      logic [7:0] raw_angular_hz;
      logic [7:0] raw_compass_hz;
      logic [7:0] temperature_hz;
      logic [7:0] every_raw_hz;
      logic [7:0] filtered_accelerometer_hz;
      logic [7:0] filtered_angular_hz;
      logic [7:0] filtered_compass_hz;
      logic [7:0] every_filtered_hz;
   } rates_type;

   typedef struct packed {
      rates_type rates;
      logic [31:0] rdata;
      logic [PRESC_W-1:0] presc;
      logic tick;
      sched_fsm_type fsm;
      batch_type batch;
   } sched_state_type;

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic due;
   } accum_state_type;

   function automatic batch_type group_batch(input logic [3:0] g);
      batch_type b;
      case (g)
         GRP_RAW_ANGULAR: b = '{ADDR_RAW_ANGULAR, LEN_RAW_SINGLE};
         GRP_RAW_ACCEL: b = '{ADDR_RAW_ACCEL, LEN_RAW_SINGLE};
         GRP_RAW_COMPASS: b = '{ADDR_RAW_COMPASS, LEN_RAW_SINGLE};
         GRP_TEMP: b = '{ADDR_TEMP, LEN_TEMP};
         GRP_ALL_RAW: b = '{ADDR_ALL_RAW, LEN_ALL_RAW};
         GRP_FILT_ANGULAR: b = '{ADDR_FILT_ANGULAR, LEN_FILT_SINGLE};
         GRP_FILT_ACCEL: b = '{ADDR_FILT_ACCEL, LEN_FILT_SINGLE};
         GRP_FILT_COMPASS: b = '{ADDR_FILT_COMPASS, LEN_FILT_SINGLE};
         default: b = '{ADDR_ALL_FILT, LEN_ALL_FILT};
      endcase
      return b;
   endfunction : group_batch
endpackage : telemetry_pkg

// ===== rate_accum.sv
/*
 Per-group pacing accumulator: raises due about rate_hz times a second.
 Assumes tick pulses once per 1/BASE_HZ second and rate_hz < BASE_HZ.
*/
`timescale 1ns/100ps
module rate_accum
   import telemetry_pkg::*;
#(
   parameter logic [ACC_W-1:0] BASE_HZ = BASE_HZ_DEF
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic tick, // base pacing pulse
   input wire logic [7:0] rate_hz, // effective rate, zero is off
   input wire logic take, // batch for this group issued
   output logic due // batch owed to the host
);
   accum_state_type q_ff;
   accum_state_type nxt_q;
   logic [ACC_W:0] sum;

   assign sum = {1'b0, q_ff.acc} + {3'b000, rate_hz};

   always_comb begin
      nxt_q = q_ff;
      if (rate_hz == 8'h00) begin
         nxt_q.acc = '0;
         nxt_q.due = 1'b0;
      end else begin
         if (take) begin
            nxt_q.due = 1'b0;
         end
         // fractional carry keeps N fires per second without drift
         if (tick) begin
            if (sum >= {1'b0, BASE_HZ}) begin
               nxt_q.acc = ACC_W'(sum - {1'b0, BASE_HZ});
               nxt_q.due = 1'b1; // set wins over take
            end else begin
               nxt_q.acc = sum[ACC_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign due = q_ff.due;
endmodule : rate_accum

// ===== telemetry_broadcast_scheduler.sv
/*
 Telemetry broadcast scheduler: rate registers, per-group pacing and
 a one-deep batch offer toward the serial packet transmitter.
 Assumes the transmitter takes a batch on pkt_valid and pkt_ready.
*/
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
module telemetry_broadcast_scheduler
   import telemetry_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF,
   parameter logic [ACC_W-1:0] BASE_HZ = BASE_HZ_DEF
) (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [7:0] reg_addr, // register index
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   output logic pkt_valid, // batch request offered
   input wire logic pkt_ready, // transmitter takes the batch
   output batch_type pkt // start address and length
);
   sched_state_type q_ff;
   sched_state_type nxt_q;
   logic [NUM_GROUPS-1:0][7:0] eff_rate;
   logic [NUM_GROUPS-1:0] zero_mask;
   logic [NUM_GROUPS-1:0] due;
   logic [NUM_GROUPS-1:0] ready_mask;
   logic [NUM_GROUPS-1:0] take;
   logic [3:0] sel;
   logic any_ready;
   logic issue;
   logic raw_override;
   logic filt_override;
   localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_CYCLES - 1);

   assign raw_override = q_ff.rates.every_raw_hz != 8'h00;
   assign filt_override = q_ff.rates.every_filtered_hz != 8'h00;

   // overridden groups see a zero rate and drop their backlog
   assign eff_rate[GRP_RAW_ANGULAR] = raw_override ? 8'h00 :
      q_ff.rates.raw_angular_hz;
   assign eff_rate[GRP_RAW_ACCEL] = raw_override ? 8'h00 :
      q_ff.rates.raw_accelerometer_hz;
   assign eff_rate[GRP_RAW_COMPASS] = raw_override ? 8'h00 :
      q_ff.rates.raw_compass_hz;
   assign eff_rate[GRP_TEMP] = raw_override ? 8'h00 :
      q_ff.rates.temperature_hz;
   assign eff_rate[GRP_ALL_RAW] = q_ff.rates.every_raw_hz;
   assign eff_rate[GRP_FILT_ANGULAR] = filt_override ? 8'h00 :
      q_ff.rates.filtered_angular_hz;
   assign eff_rate[GRP_FILT_ACCEL] = filt_override ? 8'h00 :
      q_ff.rates.filtered_accelerometer_hz;
   assign eff_rate[GRP_FILT_COMPASS] = filt_override ? 8'h00 :
      q_ff.rates.filtered_compass_hz;
   assign eff_rate[GRP_ALL_FILT] = q_ff.rates.every_filtered_hz;

   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : grp
         assign zero_mask[g] = eff_rate[g] == 8'h00;
         rate_accum #(
            .BASE_HZ(BASE_HZ)
         ) u_accum (
            .clk(clk),
            .rst_n(rst_n),
            .tick(q_ff.tick),
            .rate_hz(eff_rate[g]),
            .take(take[g]),
            .due(due[g])
         );
         assign take[g] = issue && (sel == 4'(g));
      end
   endgenerate

   // zero mask also gates the pick, so a rate just cleared never leaks
   assign ready_mask = due & ~zero_mask;

   // fixed priority: lowest group index first
   always_comb begin
      sel = 4'h0;
      any_ready = 1'b0;
      for (int i = NUM_GROUPS - 1; i >= 0; i--) begin
         if (ready_mask[i]) begin
            sel = 4'(i);
            any_ready = 1'b1;
         end
      end
   end

   assign issue = (q_ff.fsm == SCHED_IDLE) && any_ready;

   always_comb begin
      nxt_q = q_ff;
      nxt_q.rdata = 32'h00000000;
      nxt_q.tick = q_ff.presc == TICK_LAST;
      nxt_q.presc = nxt_q.tick ? '0 : q_ff.presc + 1'b1;
      if (reg_wr) begin
         case (reg_addr)
            IDX_RAW_RATES: begin
               nxt_q.rates.raw_accelerometer_hz =
                  reg_wdata[FLD_B3_LSB +: 8];
               nxt_q.rates.raw_angular_hz = reg_wdata[FLD_B2_LSB +: 8];
               nxt_q.rates.raw_compass_hz = reg_wdata[FLD_B1_LSB +: 8];
            end
            IDX_TEMP_RATES: begin
               nxt_q.rates.temperature_hz =
                  reg_wdata[FLD_B3_LSB +: 8];
               nxt_q.rates.every_raw_hz = reg_wdata[FLD_B0_LSB +: 8];
            end
            IDX_FILT_RATES: begin
               nxt_q.rates.filtered_accelerometer_hz =
                  reg_wdata[FLD_B3_LSB +: 8];
               nxt_q.rates.filtered_angular_hz = reg_wdata[FLD_B2_LSB +: 8];
               nxt_q.rates.filtered_compass_hz = reg_wdata[FLD_B1_LSB +: 8];
            end
            IDX_EVERY_FILT: begin
               nxt_q.rates.every_filtered_hz =
                  reg_wdata[FLD_B0_LSB +: 8];
            end
            default: begin
            end
         endcase
      end
      // reserved bits are dropped on write and read back as zero
      if (reg_rd) begin
         case (reg_addr)
            IDX_RAW_RATES: nxt_q.rdata = {q_ff.rates.raw_accelerometer_hz,
               q_ff.rates.raw_angular_hz, q_ff.rates.raw_compass_hz,
               8'h00};
            IDX_TEMP_RATES: nxt_q.rdata = {q_ff.rates.temperature_hz,
               16'h0000, q_ff.rates.every_raw_hz};
            IDX_FILT_RATES: nxt_q.rdata = {
               q_ff.rates.filtered_accelerometer_hz,
               q_ff.rates.filtered_angular_hz,
               q_ff.rates.filtered_compass_hz, 8'h00};
            IDX_EVERY_FILT: nxt_q.rdata = {24'h000000,
               q_ff.rates.every_filtered_hz};
            IDX_STATUS: nxt_q.rdata = {{(31 - NUM_GROUPS){1'b0}},
               q_ff.fsm == SCHED_OFFER, due};
            default: nxt_q.rdata = 32'h00000000;
         endcase
      end
      case (q_ff.fsm)
         SCHED_IDLE: begin
            if (any_ready) begin
               nxt_q.batch = group_batch(sel);
               nxt_q.fsm = SCHED_OFFER;
            end
         end
         SCHED_OFFER: begin
            // batch held steady until the transmitter takes it
            if (pkt_ready) begin
               nxt_q.fsm = SCHED_IDLE;
            end
         end
         default: nxt_q.fsm = SCHED_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff.rates <= {NUM_GROUPS{RATE_RST}};
         q_ff.rdata <= 32'h00000000;
         q_ff.presc <= '0;
         q_ff.tick <= 1'b0;
         q_ff.fsm <= SCHED_IDLE;
         q_ff.batch <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign reg_rdata = q_ff.rdata;
   assign pkt_valid = q_ff.fsm == SCHED_OFFER;
   assign pkt = q_ff.batch;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_issue_raw_single;
      issue && (sel < GRP_TEMP);
   endsequence
   sequence s_issue_filt_single;
      issue && (sel > GRP_ALL_RAW) && (sel < GRP_ALL_FILT);
   endsequence
   sequence s_accept;
      pkt_valid && pkt_ready;
   endsequence

   property p_raw_readback;
      reg_rd && (reg_addr == IDX_RAW_RATES) |=> reg_rdata ==
         {$past(q_ff.rates.raw_accelerometer_hz),
          $past(q_ff.rates.raw_angular_hz),
          $past(q_ff.rates.raw_compass_hz), 8'h00};
   endproperty
   a_raw_readback: assert property (p_raw_readback)
      else $error("raw rate readback wrong");

   property p_temp_readback;
      reg_rd && (reg_addr == IDX_TEMP_RATES) |=>
         (reg_rdata[23:8] == 16'h0000) &&
         (reg_rdata[31:24] == $past(q_ff.rates.temperature_hz)) &&
         (reg_rdata[7:0] == $past(q_ff.rates.every_raw_hz));
   endproperty
   a_temp_readback: assert property (p_temp_readback)
      else $error("temperature rate readback wrong");

   property p_filt_readback;
      reg_rd && (reg_addr == IDX_FILT_RATES) |=>
         (reg_rdata[7:0] == 8'h00) && (reg_rdata[31:24] ==
         $past(q_ff.rates.filtered_accelerometer_hz));
   endproperty
   a_filt_readback: assert property (p_filt_readback)
      else $error("filtered rate readback wrong");

   property p_zero_silent;
      1'b1 |=> (($past(zero_mask) & due) == '0) && !(issue &&
         zero_mask[sel]);
   endproperty
   a_zero_silent: assert property (p_zero_silent)
      else $error("group with zero rate still owed");

   property p_raw_batches;
      s_issue_raw_single |=> pkt_valid && (pkt.length == LEN_RAW_SINGLE)
         && (pkt.start_addr == (($past(sel) == GRP_RAW_ACCEL) ?
         ADDR_RAW_ACCEL : ($past(sel) == GRP_RAW_COMPASS) ?
         ADDR_RAW_COMPASS : ADDR_RAW_ANGULAR));
   endproperty
   a_raw_batches: assert property (p_raw_batches)
      else $error("raw batch address or length wrong");

   property p_temp_batch;
      issue && (sel == GRP_TEMP) |=> (pkt.start_addr == ADDR_TEMP) &&
         (pkt.length == LEN_TEMP);
   endproperty
   a_temp_batch: assert property (p_temp_batch)
      else $error("temperature batch wrong");

   property p_all_raw_batch;
      issue && (sel == GRP_ALL_RAW) |=> (pkt.start_addr == ADDR_ALL_RAW)
         && (pkt.length == LEN_ALL_RAW) && pkt_valid;
   endproperty
   a_all_raw_batch: assert property (p_all_raw_batch)
      else $error("every-raw batch wrong");

   property p_filt_batches;
      s_issue_filt_single |=> (pkt.length == LEN_FILT_SINGLE) &&
         (pkt.start_addr == (($past(sel) == GRP_FILT_ACCEL) ?
         ADDR_FILT_ACCEL : ($past(sel) == GRP_FILT_COMPASS) ?
         ADDR_FILT_COMPASS : ADDR_FILT_ANGULAR));
   endproperty
   a_filt_batches: assert property (p_filt_batches)
      else $error("filtered batch address or length wrong");

   property p_all_filt_batch;
      issue && (sel == GRP_ALL_FILT) |=> (pkt.start_addr ==
         ADDR_ALL_FILT) && (pkt.length == LEN_ALL_FILT);
   endproperty
   a_all_filt_batch: assert property (p_all_filt_batch)
      else $error("every-filtered batch wrong");

   property p_raw_override;
      raw_override && issue |-> (sel >= GRP_ALL_RAW);
   endproperty
   a_raw_override: assert property (p_raw_override)
      else $error("individual raw batch issued under override");

   property p_filt_override;
      filt_override |=> (due[GRP_ALL_FILT-1:GRP_FILT_ANGULAR] == '0);
   endproperty
   a_filt_override: assert property (p_filt_override)
      else $error("filtered group owed under override");

   property p_offer_hold;
      pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt);
   endproperty
   a_offer_hold: assert property (p_offer_hold)
      else $error("offered batch changed before accept");

   property p_accept_then_gap;
      s_accept |=> !pkt_valid ##1 (pkt_valid || !$past(any_ready));
   endproperty
   a_accept_then_gap: assert property (p_accept_then_gap)
      else $error("owed batch not offered after accept");
endmodule : telemetry_broadcast_scheduler

// ===== telemetry_host_model.sv
/*
 Host end of the telemetry batch stream: takes batches from the scheduler,
 promptly or with pseudo-random stalls, and reports each one it took.
 Assumes the telemetry package and the scheduler's pkt_valid/pkt_ready rule.
*/
`timescale 1ns/100ps
module telemetry_host_model
   import telemetry_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic slow, // stall the stream at random
   input wire logic pkt_valid, // batch offered by the scheduler
   input wire batch_type pkt, // offered start address and length
   output logic pkt_ready, // host can take a batch
   output logic got, // a batch was taken at the last edge
   output batch_type got_batch // the batch that was taken
);
   logic [7:0] lfsr_ff;

   // own lfsr so the stall pattern does not disturb the bench's seed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lfsr_ff <= 8'h5a;
         pkt_ready <= 1'b0;
         got <= 1'b0;
         got_batch <= '0;
      end else begin
         lfsr_ff <= {lfsr_ff[6:0], ^(lfsr_ff & 8'hb8)};
         pkt_ready <= slow ? lfsr_ff[0] : 1'b1;
         got <= pkt_valid && pkt_ready;
         got_batch <= pkt;
      end
   end
endmodule : telemetry_host_model

// ===== telemetry_broadcast_scheduler_test.sv
/*
 Self-checking bench of the telemetry broadcast scheduler: register map,
 reserved bits, group batches, overrides and per-group packet counts.
 Assumes the host model file and a shortened pacing tick.
*/
`timescale 1ns/100ps
module telemetry_broadcast_scheduler_test import telemetry_pkg::*;;
   localparam int TICK = 10;
   localparam int BASE = int'(BASE_HZ_DEF);
   localparam int W_TICKS = 100;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic pkt_valid;
   logic pkt_ready;
   logic got;
   logic slow = 1'b0;
   batch_type pkt;
   batch_type got_batch;
   logic counting = 1'b0;
   int n_fail = 0;
   int samples_checked = 0;
   int cnt [NUM_GROUPS];
   int cnt_bad;
   int e;
   logic [7:0] rate [NUM_GROUPS];
   logic [31:0] d;
   logic [8:0] en;
   logic [31:0] w [1:4];
   logic [31:0] rsv [1:4] = '{32'h000000ff, 32'h00ffff00, 32'h000000ff,
      32'hffffff00};
   // group masks in package group order; 01f and 1e0 mix an override with its groups
   logic [8:0] case_en [12] = '{9'h000, 9'h002, 9'h001, 9'h004, 9'h008,
      9'h01f, 9'h040, 9'h020, 9'h080, 9'h1e0, 9'h0ef, 9'h110};

   always #(CLK_PERIOD_NS / 2) clk = ~clk;

   telemetry_broadcast_scheduler #(
      .TICK_CYCLES(TICK),
      .BASE_HZ(BASE_HZ_DEF)
   ) uut (
      .clk(clk),
      .rst_n(rst_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .pkt_valid(pkt_valid),
      .pkt_ready(pkt_ready),
      .pkt(pkt)
   );

   telemetry_host_model host (
      .clk(clk),
      .rst_n(rst_n),
      .slow(slow),
      .pkt_valid(pkt_valid),
      .pkt(pkt),
      .pkt_ready(pkt_ready),
      .got(got),
      .got_batch(got_batch)
   );

   function automatic batch_type exp_batch(input int g);
      case (g)
         0: return '{8'h56, 4'h3};
         1: return '{8'h59, 4'h3};
         2: return '{8'h5c, 4'h3};
         3: return '{8'h5f, 4'h2};
         4: return '{8'h56, 4'hb};
         5: return '{8'h64, 4'h4};
         6: return '{8'h68, 4'h4};
         7: return '{8'h6c, 4'h4};
         default: return '{8'h61, 4'hc};
      endcase
   endfunction : exp_batch

   function automatic int eff_rate(input int g);
      if (g < 4 && rate[4] != 8'h00) return 0;
      if (g > 4 && g < 8 && rate[8] != 8'h00) return 0;
      return int'(rate[g]);
   endfunction : eff_rate

   task automatic check_word(input logic [31:0] got_v,
      input logic [31:0] exp_v);
      samples_checked++;
      if (got_v !== exp_v) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got_v,
            exp_v);
      end
   endtask : check_word

   task automatic check_count(input int got_v, input int exp_v,
      input int tol);
      samples_checked++;
      if (got_v < exp_v - tol || got_v > exp_v + tol) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got_v,
            exp_v);
      end
   endtask : check_count

   // write strobe stays up into the next task; a read lowers its own
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      // data stand only in the cycle after the strobe: take them at its end
      @(posedge clk);
      v = reg_rdata;
   endtask : bus_rd

   task automatic do_reset();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask : do_reset

   task automatic final_report();
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   // a batch that matches no group is counted as stray
   always @(posedge clk) begin
      if (counting && got === 1'b1) begin
         cnt_bad++;
         for (int g = 0; g < NUM_GROUPS; g++)
            if (got_batch === exp_batch(g)) begin
               cnt[g]++;
               cnt_bad--;
            end
      end
   end

   initial begin
      void'($urandom(57863));
      do_reset();
      for (int a = 0; a < 6; a++) begin
         bus_rd(8'(a), d);
         check_word(d, 32'h00000000);
      end
      // status: nothing owed and no offer while every rate is zero
      bus_rd(8'h10, d);
      check_word(d, 32'h00000000);
      foreach (case_en[c]) begin
         en = case_en[c];
         // odd cases always stall, so the hold-while-offered path is hit
         slow <= 1'(c) | 1'($urandom % 2);
         do_reset();
         for (int g = 0; g < NUM_GROUPS; g++) begin
            if (!en[g]) rate[g] = 8'h00;
            else if ($countones(en) == 1) rate[g] = 8'hff;
            else rate[g] = 8'(50 + $urandom % 151);
            cnt[g] = 0;
         end
         cnt_bad = 0;
         w[1] = {rate[1], rate[0], rate[2], 8'h00};
         w[2] = {rate[3], 16'h0000, rate[4]};
         w[3] = {rate[6], rate[5], rate[7], 8'h00};
         w[4] = {24'h000000, rate[8]};
         // junk in reserved bits must neither read back nor pace anything
         for (int a = 1; a <= 4; a++)
            bus_wr(8'(a), w[a] | ($urandom & rsv[a]));
         bus_wr(8'h05, $urandom);
         for (int a = 1; a <= 4; a++) begin
            bus_rd(8'(a), d);
            check_word(d, w[a]);
         end
         bus_rd(8'h05, d);
         check_word(d, 32'h00000000);
         counting <= 1'b1;
         repeat (W_TICKS * TICK) @(posedge clk);
         #1;
         counting = 1'b0;
         check_count(cnt_bad, 0, 0);
         // window phase against the tick allows one packet either way
         for (int g = 0; g < NUM_GROUPS; g++) begin
            e = eff_rate(g);
            check_count(cnt[g], e * W_TICKS / BASE, e != 0);
         end
      end
      final_report();
   end

   initial begin
      #400000;
      n_fail++;
      final_report();
   end
endmodule : telemetry_broadcast_scheduler_test
